// *** hw/pll_cfg_pkg.sv ***
package pll_cfg_pkg;

    // ************************************************************
    // Register byte addresses of the feedback and loop bank.
    // ************************************************************
    localparam logic [15:0] ADDR_RATIO0_HIGH = 16'h004A;
    localparam logic [15:0] ADDR_RATIO0_MID = 16'h004B;
    localparam logic [15:0] ADDR_RATIO0_LOW = 16'h004C;
    localparam logic [15:0] ADDR_RATIO1_HIGH = 16'h004D;
    localparam logic [15:0] ADDR_RATIO1_MID = 16'h004E;
    localparam logic [15:0] ADDR_RATIO1_LOW = 16'h004F;
    localparam logic [15:0] ADDR_BANDWIDTH = 16'h0056;
    localparam logic [15:0] ADDR_DAMP_GAIN = 16'h0057;
    localparam logic [15:0] ADDR_ONES_FIRST = 16'h005E;
    localparam logic [15:0] ADDR_ONES_LAST = 16'h0061;
    localparam logic [15:0] ADDR_SLEW_HOLD = 16'h0062;
    localparam logic [15:0] ADDR_LOCK_THRESH = 16'h0063;
    localparam logic [15:0] ADDR_MOD_INT_HIGH = 16'h0064;
    localparam logic [15:0] ADDR_MOD_INT_LOW = 16'h0065;
    localparam logic [15:0] ADDR_MOD_FRAC_HIGH = 16'h0066;
    localparam logic [15:0] ADDR_MOD_FRAC_MID = 16'h0067;
    localparam logic [15:0] ADDR_MOD_FRAC_LOW = 16'h0068;
    localparam logic [15:0] ADDR_FIXED_ONE = 16'h006A;
    localparam logic [15:0] ADDR_DITHER = 16'h006D;

    // ************************************************************
    // Fixed read values of locations that hold no storage.
    // ************************************************************
    localparam logic [7:0] READ_ONES = 8'hFF;
    localparam logic [7:0] READ_FIXED_ONE = 8'h01;
    localparam logic [7:0] READ_RESERVED = 8'h00;

    // ************************************************************
    // Writable bit masks; reserved positions are kept at zero.
    // ************************************************************
    localparam logic [7:0] MASK_SLEW_HOLD = 8'hDB;
    localparam logic [7:0] MASK_MOD_INT_HIGH = 8'h01;
    localparam logic [7:0] MASK_MOD_FRAC_HIGH = 8'h1F;
    localparam logic [7:0] MASK_DITHER = 8'hF7;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int BW_LOCKED_LSB = 4;
    localparam int BW_ACQUIRE_LSB = 0;
    localparam int DAMP_LOCKED_LSB = 5;
    localparam int DAMP_ACQUIRE_LSB = 2;
    localparam int GAIN_LSB = 0;
    localparam int SLEW_LSB = 6;
    localparam int HOLD_LSB = 3;
    localparam int HOLD_AVG_BIT = 1;
    localparam int FAST_LOCK_BIT = 0;
    localparam int MOD_ORDER_LSB = 6;
    localparam int OSC_MULT_LSB = 4;
    localparam int DITHER_LSB = 0;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [23:0] RESET_RATIO = 24'h070000;
    localparam logic [7:0] RESET_BANDWIDTH = 8'h77;
    localparam logic [7:0] RESET_DAMP_GAIN = 8'h6D;
    localparam logic [7:0] RESET_OTHER = 8'h00;

    // ************************************************************
    // Legal code ranges of bandwidth and damping.
    // ************************************************************
    localparam logic [3:0] BW_CODE_MIN = 4'h3;
    localparam logic [3:0] BW_CODE_MAX = 4'hB;
    localparam logic [2:0] DAMP_CODE_MIN = 3'h1;
    localparam logic [2:0] DAMP_CODE_MAX = 3'h5;

    // A byte access from the serial management port engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // The loop settings that the filter applies at one moment.
    typedef struct packed {
        logic [3:0] bw_code;
        logic [2:0] damp_code;
        logic [1:0] gain_code;
    } loop_set_s;

    // True when a code lies inside an inclusive legal range.
    function automatic logic code_in_range(input logic [3:0] code,
                                           input logic [3:0] lo,
                                           input logic [3:0] hi);
        code_in_range = (code >= lo) && (code <= hi);
    endfunction : code_in_range

endpackage : pll_cfg_pkg

// *** hw/loop_mode_select.sv ***
`timescale 1ns/1ps
module loop_mode_select
    import pll_cfg_pkg::*;
(
    input wire logic fast_lock_enable,
    input wire logic phase_locked,
    input wire logic [3:0] locked_bandwidth_code,
    input wire logic [3:0] acquire_bandwidth_code,
    input wire logic [2:0] locked_damping_code,
    input wire logic [2:0] acquire_damping_code,
    output logic [3:0] bw_code,
    output logic [2:0] damp_code,
    output logic use_acquire
);

    // ************************************************************
    // Choice between locked and acquisition settings.
    // ************************************************************

    // Acquisition settings apply only with fast lock on and no phase lock.
    always_comb begin
        use_acquire = fast_lock_enable && !phase_locked;
        if (use_acquire) begin
            bw_code = acquire_bandwidth_code;
            damp_code = acquire_damping_code;
        end else begin
            bw_code = locked_bandwidth_code;
            damp_code = locked_damping_code;
        end
    end

endmodule : loop_mode_select

// *** hw/loop_code_decode.sv ***
`timescale 1ns/1ps
module loop_code_decode
    import pll_cfg_pkg::*;
(
    input wire loop_set_s settings,
    output logic [3:0] bw_shift,
    output logic bw_reserved,
    output logic [4:0] damp_factor,
    output logic damp_reserved,
    output logic [2:0] gain_halves
);

    // ************************************************************
    // Decoding of the applied codes into filter quantities.
    // ************************************************************

    // Bandwidth is 1.40625 Hz shifted left by this count; reserved codes give zero.
    always_comb begin
        bw_reserved = !code_in_range(settings.bw_code, BW_CODE_MIN, BW_CODE_MAX);
        if (bw_reserved) begin
            bw_shift = 4'h0;
        end else begin
            bw_shift = settings.bw_code - BW_CODE_MIN;
        end
    end

    // Damping factor as a whole number; a reserved code yields zero.
    always_comb begin
        damp_reserved = !code_in_range({1'b0, settings.damp_code},
                                       {1'b0, DAMP_CODE_MIN},
                                       {1'b0, DAMP_CODE_MAX});
        case (settings.damp_code)
            3'h1: damp_factor = 5'h01;
            3'h2: damp_factor = 5'h02;
            3'h3: damp_factor = 5'h05;
            3'h4: damp_factor = 5'h0A;
            3'h5: damp_factor = 5'h14;
            default: damp_factor = 5'h00;
        endcase
    end

    // Filter gain counted in halves, so 0.5 to 2 become 1 to 4.
    always_comb begin
        gain_halves = {1'b0, settings.gain_code} + 3'h1;
    end

endmodule : loop_code_decode

// *** hw/pll_feedback_loop_config.sv ***
// How it works
// - Reference 0 uses its own 24-bit feedback ratio.
// - Reference 1 uses its separate 24-bit feedback ratio.
// - Locked bandwidth code doubles per step, 0011-1011.
// - Acquisition bandwidth code, same encoding, resets 0111.
// - Locked damping code maps to 1,2,5,10,20.
// - Acquisition damping code, same encoding, resets 011.
// - Gain code scales filter by 0.5 to 2.
// - Fast lock off means locked settings always.
`timescale 1ns/1ps
module pll_feedback_loop_config
    import pll_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire reg_req_s req,
    input wire logic ref_select,
    input wire logic phase_locked,
    output logic [7:0] rd_data_reg,
    output logic rd_valid_reg,
    output logic [23:0] feedback_ratio_reg,
    output loop_set_s loop_set_reg,
    output logic use_acquire_reg,
    output logic [3:0] bw_shift_reg,
    output logic [4:0] damp_factor_reg,
    output logic [2:0] gain_halves_reg,
    output logic code_reserved_reg,
    output logic [1:0] phase_slope_limit,
    output logic [1:0] holdover_method,
    output logic holdover_averaging,
    output logic fast_lock_enable,
    output logic [7:0] lock_threshold_value,
    output logic [8:0] modulator_integer_part,
    output logic [20:0] modulator_fraction_part,
    output logic [1:0] modulator_order,
    output logic [1:0] oscillator_error_multiplier,
    output logic [2:0] dither_gain_code
);

    // ************************************************************
    // Storage of the bank.
    // ************************************************************
    logic [23:0] ratio0_reg; // Feedback ratio for reference 0.
    logic [23:0] ratio0_next;
    logic [23:0] ratio1_reg; // Feedback ratio for reference 1.
    logic [23:0] ratio1_next;
    logic [7:0] bandwidth_reg; // Locked and acquisition bandwidth codes.
    logic [7:0] bandwidth_next;
    logic [7:0] damp_gain_reg; // Damping codes and filter gain code.
    logic [7:0] damp_gain_next;
    logic [7:0] slew_hold_reg; // Slope limit, holdover and fast lock.
    logic [7:0] slew_hold_next;
    logic [7:0] lock_thresh_reg; // Lock detector threshold.
    logic [7:0] lock_thresh_next;
    logic [8:0] mod_int_reg; // Modulator integer part.
    logic [8:0] mod_int_next;
    logic [20:0] mod_frac_reg; // Modulator fractional part.
    logic [20:0] mod_frac_next;
    logic [7:0] dither_reg; // Modulator order, multiplier and dither.
    logic [7:0] dither_next;

    // ************************************************************
    // Read path and applied-setting pipeline.
    // ************************************************************
    logic [7:0] rd_data_next; // Byte returned one cycle after a read.
    logic rd_valid_next; // Marks the returned byte.
    logic [23:0] feedback_ratio_next; // Ratio for the tracked reference.
    loop_set_s loop_set_next; // Codes the loop filter should use.
    logic use_acquire_next;
    logic [3:0] bw_shift_next;
    logic [4:0] damp_factor_next;
    logic [2:0] gain_halves_next;
    logic code_reserved_next;

    // ************************************************************
    // Wires from the two helper blocks.
    // ************************************************************
    logic [3:0] sel_bw_code;
    logic [2:0] sel_damp_code;
    logic sel_use_acquire;
    loop_set_s sel_set;
    logic [3:0] dec_bw_shift;
    logic dec_bw_reserved;
    logic [4:0] dec_damp_factor;
    logic dec_damp_reserved;
    logic [2:0] dec_gain_halves;

    // ************************************************************
    // Register writes.
    // ************************************************************

    // One byte is written per strobe; reserved positions are masked so they
    // always read back as zero even if software disobeys the write-zero advice.
    always_comb begin
        ratio0_next = ratio0_reg;
        ratio1_next = ratio1_reg;
        bandwidth_next = bandwidth_reg;
        damp_gain_next = damp_gain_reg;
        slew_hold_next = slew_hold_reg;
        lock_thresh_next = lock_thresh_reg;
        mod_int_next = mod_int_reg;
        mod_frac_next = mod_frac_reg;
        dither_next = dither_reg;
        if (req.wr) begin
            if (req.addr == ADDR_RATIO0_HIGH) begin
                ratio0_next[23:16] = req.wdata;
            end else if (req.addr == ADDR_RATIO0_MID) begin
                ratio0_next[15:8] = req.wdata;
            end else if (req.addr == ADDR_RATIO0_LOW) begin
                ratio0_next[7:0] = req.wdata;
            end else if (req.addr == ADDR_RATIO1_HIGH) begin
                ratio1_next[23:16] = req.wdata;
            end else if (req.addr == ADDR_RATIO1_MID) begin
                ratio1_next[15:8] = req.wdata;
            end else if (req.addr == ADDR_RATIO1_LOW) begin
                ratio1_next[7:0] = req.wdata;
            end else if (req.addr == ADDR_BANDWIDTH) begin
                bandwidth_next = req.wdata;
            end else if (req.addr == ADDR_DAMP_GAIN) begin
                damp_gain_next = req.wdata;
            end else if (req.addr == ADDR_SLEW_HOLD) begin
                slew_hold_next = req.wdata & MASK_SLEW_HOLD;
            end else if (req.addr == ADDR_LOCK_THRESH) begin
                lock_thresh_next = req.wdata;
            end else if (req.addr == ADDR_MOD_INT_HIGH) begin
                mod_int_next[8] = req.wdata[0];
            end else if (req.addr == ADDR_MOD_INT_LOW) begin
                mod_int_next[7:0] = req.wdata;
            end else if (req.addr == ADDR_MOD_FRAC_HIGH) begin
                mod_frac_next[20:16] = req.wdata[4:0];
            end else if (req.addr == ADDR_MOD_FRAC_MID) begin
                mod_frac_next[15:8] = req.wdata;
            end else if (req.addr == ADDR_MOD_FRAC_LOW) begin
                mod_frac_next[7:0] = req.wdata;
            end else if (req.addr == ADDR_DITHER) begin
                dither_next = req.wdata & MASK_DITHER;
            end
        end
    end

    // Storage flip-flops take their documented defaults at reset.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ratio0_reg <= RESET_RATIO;
            ratio1_reg <= RESET_RATIO;
            bandwidth_reg <= RESET_BANDWIDTH;
            damp_gain_reg <= RESET_DAMP_GAIN;
            slew_hold_reg <= RESET_OTHER;
            lock_thresh_reg <= RESET_OTHER;
            mod_int_reg <= 9'h000;
            mod_frac_reg <= 21'h000000;
            dither_reg <= RESET_OTHER;
        end else begin
            ratio0_reg <= ratio0_next;
            ratio1_reg <= ratio1_next;
            bandwidth_reg <= bandwidth_next;
            damp_gain_reg <= damp_gain_next;
            slew_hold_reg <= slew_hold_next;
            lock_thresh_reg <= lock_thresh_next;
            mod_int_reg <= mod_int_next;
            mod_frac_reg <= mod_frac_next;
            dither_reg <= dither_next;
        end
    end

    // ************************************************************
    // Field outputs taken straight from storage.
    // ************************************************************
    assign phase_slope_limit = slew_hold_reg[SLEW_LSB +: 2];
    assign holdover_method = slew_hold_reg[HOLD_LSB +: 2];
    assign holdover_averaging = slew_hold_reg[HOLD_AVG_BIT];
    assign fast_lock_enable = slew_hold_reg[FAST_LOCK_BIT];
    assign lock_threshold_value = lock_thresh_reg;
    assign modulator_integer_part = mod_int_reg;
    assign modulator_fraction_part = mod_frac_reg;
    assign modulator_order = dither_reg[MOD_ORDER_LSB +: 2];
    assign oscillator_error_multiplier = dither_reg[OSC_MULT_LSB +: 2];
    assign dither_gain_code = dither_reg[DITHER_LSB +: 3];

    // ************************************************************
    // Selection and decoding of the applied loop settings.
    // ************************************************************
    loop_mode_select u_mode_select (
        .fast_lock_enable(slew_hold_reg[FAST_LOCK_BIT]),
        .phase_locked(phase_locked),
        .locked_bandwidth_code(bandwidth_reg[BW_LOCKED_LSB +: 4]),
        .acquire_bandwidth_code(bandwidth_reg[BW_ACQUIRE_LSB +: 4]),
        .locked_damping_code(damp_gain_reg[DAMP_LOCKED_LSB +: 3]),
        .acquire_damping_code(damp_gain_reg[DAMP_ACQUIRE_LSB +: 3]),
        .bw_code(sel_bw_code),
        .damp_code(sel_damp_code),
        .use_acquire(sel_use_acquire)
    );

    // The gain code is shared by both loop states.
    assign sel_set = '{bw_code: sel_bw_code, damp_code: sel_damp_code,
                       gain_code: damp_gain_reg[GAIN_LSB +: 2]};

    loop_code_decode u_code_decode (
        .settings(sel_set),
        .bw_shift(dec_bw_shift),
        .bw_reserved(dec_bw_reserved),
        .damp_factor(dec_damp_factor),
        .damp_reserved(dec_damp_reserved),
        .gain_halves(dec_gain_halves)
    );

    // ************************************************************
    // Read decode and applied-setting next values.
    // ************************************************************

    // Read data is registered so every output leaves a flip-flop; holes in the
    // map answer zero, and the fixed locations answer their constant bytes.
    always_comb begin
        rd_valid_next = req.rd;
        rd_data_next = rd_data_reg;
        if (req.rd) begin
            if (req.addr == ADDR_RATIO0_HIGH) begin
                rd_data_next = ratio0_reg[23:16];
            end else if (req.addr == ADDR_RATIO0_MID) begin
                rd_data_next = ratio0_reg[15:8];
            end else if (req.addr == ADDR_RATIO0_LOW) begin
                rd_data_next = ratio0_reg[7:0];
            end else if (req.addr == ADDR_RATIO1_HIGH) begin
                rd_data_next = ratio1_reg[23:16];
            end else if (req.addr == ADDR_RATIO1_MID) begin
                rd_data_next = ratio1_reg[15:8];
            end else if (req.addr == ADDR_RATIO1_LOW) begin
                rd_data_next = ratio1_reg[7:0];
            end else if (req.addr == ADDR_BANDWIDTH) begin
                rd_data_next = bandwidth_reg;
            end else if (req.addr == ADDR_DAMP_GAIN) begin
                rd_data_next = damp_gain_reg;
            end else if (req.addr >= ADDR_ONES_FIRST && req.addr <= ADDR_ONES_LAST) begin
                rd_data_next = READ_ONES;
            end else if (req.addr == ADDR_SLEW_HOLD) begin
                rd_data_next = slew_hold_reg;
            end else if (req.addr == ADDR_LOCK_THRESH) begin
                rd_data_next = lock_thresh_reg;
            end else if (req.addr == ADDR_MOD_INT_HIGH) begin
                rd_data_next = {7'h00, mod_int_reg[8]};
            end else if (req.addr == ADDR_MOD_INT_LOW) begin
                rd_data_next = mod_int_reg[7:0];
            end else if (req.addr == ADDR_MOD_FRAC_HIGH) begin
                rd_data_next = {3'h0, mod_frac_reg[20:16]};
            end else if (req.addr == ADDR_MOD_FRAC_MID) begin
                rd_data_next = mod_frac_reg[15:8];
            end else if (req.addr == ADDR_MOD_FRAC_LOW) begin
                rd_data_next = mod_frac_reg[7:0];
            end else if (req.addr == ADDR_FIXED_ONE) begin
                rd_data_next = READ_FIXED_ONE;
            end else if (req.addr == ADDR_DITHER) begin
                rd_data_next = dither_reg;
            end else begin
                rd_data_next = READ_RESERVED;
            end
        end
    end

    // The applied settings follow the stored ones one cycle later; a
    // multi-byte ratio is assembled byte by byte, so software should
    // change it only while the reference is not being tracked.
    always_comb begin
        if (ref_select) begin
            feedback_ratio_next = ratio1_reg;
        end else begin
            feedback_ratio_next = ratio0_reg;
        end
        loop_set_next = sel_set;
        use_acquire_next = sel_use_acquire;
        bw_shift_next = dec_bw_shift;
        damp_factor_next = dec_damp_factor;
        gain_halves_next = dec_gain_halves;
        code_reserved_next = dec_bw_reserved || dec_damp_reserved;
    end

    // Output flip-flops; reset values match the decode of the reset codes.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            feedback_ratio_reg <= RESET_RATIO;
            loop_set_reg <= '{bw_code: 4'h7, damp_code: 3'h3, gain_code: 2'h1};
            use_acquire_reg <= 1'b0;
            bw_shift_reg <= 4'h4;
            damp_factor_reg <= 5'h05;
            gain_halves_reg <= 3'h2;
            code_reserved_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            feedback_ratio_reg <= feedback_ratio_next;
            loop_set_reg <= loop_set_next;
            use_acquire_reg <= use_acquire_next;
            bw_shift_reg <= bw_shift_next;
            damp_factor_reg <= damp_factor_next;
            gain_halves_reg <= gain_halves_next;
            code_reserved_reg <= code_reserved_next;
        end
    end

endmodule : pll_feedback_loop_config

// *** verification/pll_feedback_loop_config_properties.sv ***
`timescale 1ns/1ps
// ************************************************************
// Checker of the applied feedback and loop settings.
// ************************************************************
module pll_feedback_loop_config_properties
    import pll_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire reg_req_s req,
    input wire logic ref_select,
    input wire logic phase_locked,
    input wire logic [23:0] feedback_ratio_reg,
    input wire loop_set_s loop_set_reg,
    input wire logic use_acquire_reg,
    input wire logic fast_lock_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // A write is stored at its edge and applied one edge later, so the mode is judged then.
    sequence wr_at(logic [15:0] a); req.wr && req.addr == a; endsequence
    sequence locked_mode; !fast_lock_enable || phase_locked; endsequence
    sequence acq_mode; fast_lock_enable && !phase_locked; endsequence
    a_ratio_ref0: assert property (
        wr_at(ADDR_RATIO0_LOW) ##1 !ref_select |=> feedback_ratio_reg[7:0] == $past(req.wdata, 2))
        else $error("reference 0 ratio not applied");
    a_ratio_ref1: assert property (
        wr_at(ADDR_RATIO1_HIGH) ##1 ref_select |=> feedback_ratio_reg[23:16] == $past(req.wdata, 2))
        else $error("reference 1 ratio not applied");
    a_bw_locked: assert property (
        wr_at(ADDR_BANDWIDTH) ##1 locked_mode |=> loop_set_reg.bw_code == $past(req.wdata[7:4], 2))
        else $error("locked bandwidth not applied");
    a_bw_acquire: assert property (
        wr_at(ADDR_BANDWIDTH) ##1 acq_mode |=> loop_set_reg.bw_code == $past(req.wdata[3:0], 2))
        else $error("acquisition bandwidth not applied");
    a_damp_locked: assert property (
        wr_at(ADDR_DAMP_GAIN) ##1 locked_mode |=> loop_set_reg.damp_code == $past(req.wdata[7:5], 2))
        else $error("locked damping not applied");
    a_damp_acquire: assert property (
        wr_at(ADDR_DAMP_GAIN) ##1 acq_mode |=> loop_set_reg.damp_code == $past(req.wdata[4:2], 2))
        else $error("acquisition damping not applied");
    a_gain_code: assert property (
        wr_at(ADDR_DAMP_GAIN) |=> ##1 loop_set_reg.gain_code == $past(req.wdata[1:0], 2))
        else $error("filter gain not applied");
    a_fast_off: assert property (
        locked_mode |=> !use_acquire_reg)
        else $error("acquisition codes used while not allowed");
endmodule : pll_feedback_loop_config_properties
bind pll_feedback_loop_config pll_feedback_loop_config_properties checker_i (.clk(clk), .nrst(nrst),
    .req(req), .ref_select(ref_select), .phase_locked(phase_locked),
    .feedback_ratio_reg(feedback_ratio_reg), .loop_set_reg(loop_set_reg),
    .use_acquire_reg(use_acquire_reg), .fast_lock_enable(fast_lock_enable));

// *** verification/pll_feedback_loop_config_test.sv ***
`timescale 1ns/1ps
module pll_feedback_loop_config_test
    import pll_cfg_pkg::*;
;
    // ************************************************************
    // Stimulus and observed outputs.
    // ************************************************************
    logic clk = 1'b0;
    logic nrst = 1'b0;
    reg_req_s req = '0;
    logic ref_select = 1'b0;
    logic phase_locked = 1'b1;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg, code_reserved_reg;
    logic [23:0] feedback_ratio_reg;
    loop_set_s loop_set_reg;
    logic [3:0] bw_shift_reg;
    logic [4:0] damp_factor_reg;
    logic [2:0] gain_halves_reg, dither_gain_code;
    int n_errors = 0;
    int checks = 0;
    // Damping factors of codes 1 to 5.
    localparam logic [4:0] FACTOR [0:4] = '{5'h01, 5'h02, 5'h05, 5'h0A, 5'h14};
    always #25 clk = ~clk;
    pll_feedback_loop_config uut (.clk(clk), .nrst(nrst), .req(req), .ref_select(ref_select),
        .phase_locked(phase_locked), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
        .feedback_ratio_reg(feedback_ratio_reg), .loop_set_reg(loop_set_reg),
        .use_acquire_reg(), .bw_shift_reg(bw_shift_reg), .damp_factor_reg(damp_factor_reg),
        .gain_halves_reg(gain_halves_reg), .code_reserved_reg(code_reserved_reg),
        .phase_slope_limit(), .holdover_method(), .holdover_averaging(), .fast_lock_enable(),
        .lock_threshold_value(), .modulator_integer_part(), .modulator_fraction_part(),
        .modulator_order(), .oscillator_error_multiplier(), .dither_gain_code(dither_gain_code));
    // ************************************************************
    // Access tasks; every input moves on the falling edge.
    // ************************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk); req.wr = 1'b1; req.addr = a; req.wdata = d;
        @(negedge clk); req.wr = 1'b0;
    endtask : wr
    // The answer pulse lasts one cycle, so the wait is bounded and a miss ends the run.
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        int n;
        @(negedge clk); req.rd = 1'b1; req.addr = a;
        @(negedge clk); req.rd = 1'b0; n = 0;
        while (rd_valid_reg !== 1'b1 && n < 4) begin @(negedge clk); n++; end
        if (n == 4) begin n_errors++; test_done; end
        else check(24'(rd_data_reg), 24'(e));
    endtask : rd
    // Derived outputs follow a stored byte by one more edge.
    task automatic settle; repeat (2) @(negedge clk); endtask : settle
    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        logic [47:0] rv;
        rv = 48'h123456ABCDEF;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        rd(ADDR_RATIO0_HIGH, 8'h07);
        rd(ADDR_RATIO1_HIGH, 8'h07);
        rd(ADDR_BANDWIDTH, 8'h77);
        rd(ADDR_DAMP_GAIN, 8'h6D);
        check(feedback_ratio_reg, 24'h070000);
        check(24'(bw_shift_reg), 24'h4);
        check(24'(damp_factor_reg), 24'h5);
        check(24'(gain_halves_reg), 24'h2);
        $display("test reset done");
        for (int i = 0; i < 6; i++) wr(16'(ADDR_RATIO0_HIGH + i), rv[47 - 8 * i -: 8]);
        settle; check(feedback_ratio_reg, rv[47:24]);
        ref_select = 1'b1;
        settle; check(feedback_ratio_reg, rv[23:0]);
        wr(ADDR_RATIO1_HIGH, 8'h5A);
        settle; check(feedback_ratio_reg, {8'h5A, rv[15:0]});
        $display("test ratios done");
        wr(ADDR_SLEW_HOLD, 8'hFF);
        rd(ADDR_SLEW_HOLD, 8'hDB);
        rd(16'h0050, 8'h00);
        wr(ADDR_DITHER, 8'hFF);
        rd(ADDR_DITHER, 8'hF7);
        check(24'(dither_gain_code), 24'h7);
        rd(ADDR_FIXED_ONE, 8'h01);
        // Fast lock is on now, so the lock input picks the bandwidth code.
        for (int i = 3; i < 12; i++) begin
            wr(ADDR_BANDWIDTH, {4'(i), 4'(14 - i)});
            phase_locked = 1'b1;
            settle; check(24'(bw_shift_reg), 24'(i - 3));
            phase_locked = 1'b0;
            settle; check(24'(bw_shift_reg), 24'(11 - i));
        end
        wr(ADDR_BANDWIDTH, 8'hC7);
        wr(ADDR_SLEW_HOLD, 8'h00);
        settle; check(24'(loop_set_reg.bw_code), 24'hC);
        check(24'(code_reserved_reg), 24'h1);
        $display("test bandwidth done");
        for (int i = 1; i < 6; i++) begin
            wr(ADDR_DAMP_GAIN, {3'(i), 3'(6 - i), 2'(i)});
            settle; check(24'(damp_factor_reg), 24'(FACTOR[i - 1]));
            check(24'(gain_halves_reg), 24'((i % 4) + 1));
        end
        wr(ADDR_SLEW_HOLD, 8'h01);
        wr(ADDR_DAMP_GAIN, 8'h34);
        settle; check(24'(damp_factor_reg), 24'h14);
        check(24'(gain_halves_reg), 24'h1);
        $display("test damping done");
        test_done;
    end
endmodule : pll_feedback_loop_config_test
